// ==== design/rxw_pkg.sv ====
/*
  package for the receive extended-status writeback block: descriptor word
  field positions, message and payload type codes, register offsets.
  assumes nothing beyond a SystemVerilog compiler.
*/
package rxw_pkg;
  // descriptor word 4 field positions
  localparam int unsigned W4_TS_DROP_BIT   = 14;
  localparam int unsigned W4_PTP_VER_BIT   = 13;
  localparam int unsigned W4_PTP_ETH_BIT   = 12;
  localparam int unsigned W4_MSG_LSB       = 8;
  localparam int unsigned W4_IPV6_BIT      = 7;
  localparam int unsigned W4_IPV4_BIT      = 6;
  localparam int unsigned W4_BYPASS_BIT    = 5;
  localparam int unsigned W4_PAY_ERR_BIT   = 4;
  localparam int unsigned W4_HDR_ERR_BIT   = 3;
  localparam int unsigned W4_PAY_TYPE_LSB  = 0;
  // last-descriptor bit of descriptor word 0
  localparam int unsigned W0_LAST_BIT      = 8;
  // message type codes
  localparam logic [3:0] MSG_NONE          = 4'h0;
  localparam logic [3:0] MSG_PDRESP_FUP    = 4'h7;
  localparam logic [3:0] MSG_ANNOUNCE      = 4'h8;
  localparam logic [3:0] MSG_SIGNALING     = 4'ha;
  localparam logic [3:0] MSG_RESERVED      = 4'hf;
  // payload type codes
  localparam logic [2:0] PAY_UNKNOWN       = 3'h0;
  localparam logic [2:0] PAY_UDP           = 3'h1;
  localparam logic [2:0] PAY_TCP           = 3'h2;
  localparam logic [2:0] PAY_ICMP          = 3'h3;
  // register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL          = 8'h00;
  localparam logic [7:0] REG_STATUS        = 8'h04;
  localparam logic [7:0] REG_CLEAR         = 8'h08;
  localparam logic [7:0] REG_IRQ_EN        = 8'h0c;
  localparam logic [7:0] REG_LAST_W4       = 8'h10;
  localparam logic [7:0] REG_FRAMES        = 8'h14;
  // reset values
  localparam logic [31:0] RST_CTRL         = 32'h0000_0001;
  localparam logic [2:0]  RST_IRQ_EN       = 3'h0;
  // event bits of status / clear / enable registers
  localparam int unsigned EV_DONE          = 0;
  localparam int unsigned EV_TS_DROP       = 1;
  localparam int unsigned EV_CSUM_ERR      = 2;
  localparam int unsigned EV_COUNT         = 3;
  // writeback states
  typedef enum logic [1:0] {ST_IDLE, ST_W4, ST_W6, ST_W7} rxw_state_type;
endpackage

// ==== design/rxw_wb_if.sv ====
/*
  interface carrying descriptor writes from the status composer to the
  writeback sequencer. assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none
interface rxw_wb_if;
  logic        frame_valid;  // one-cycle: new frame summary ready
  logic [31:0] word4;        // composed extended status
  logic [63:0] stamp;        // captured timestamp
  logic        is_last;      // frame closes in last descriptor
  logic        busy;         // sequencer still writing
  modport src (output frame_valid, word4, stamp, is_last, input busy);
  modport dst (input frame_valid, word4, stamp, is_last, output busy);
endinterface
`default_nettype wire

// ==== design/rxw_compose.sv ====
/*
  composes descriptor word 4 from receive path status at frame end.
  assumes frame end and status inputs come from logic on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module rxw_compose
  import rxw_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // receive path summary
  input  wire logic        frame_end,
  input  wire logic        is_last,
  input  wire logic [63:0] stamp,
  input  wire logic        ts_captured,
  input  wire logic        fifo_overflow,
  input  wire logic        ptp_v2,
  input  wire logic        ptp_over_eth,
  input  wire logic [3:0]  ptp_msg,
  input  wire logic        is_ipv6,
  input  wire logic        is_ipv4,
  input  wire logic        csum_engine_bypass,
  input  wire logic        pay_csum_bad,
  input  wire logic        seg_len_bad,
  input  wire logic        hdr_csum_bad,
  input  wire logic        ver_mismatch,
  input  wire logic        is_fragment,
  input  wire logic [2:0]  l4_kind,
  input  wire logic        csum_offload_enable,
  // toward sequencer
  rxw_wb_if.src            wb
);
  // ip flags hold their last value while offload is off
  logic ipv6_r;
  logic ipv4_r;
  logic ipv6_nxt;
  logic ipv4_nxt;
  logic ip_any;
  logic hdr_err;
  logic pay_err;
  logic [3:0] msg_code;
  logic [2:0] pay_code;
  logic [31:0] w4_nxt;

  assign ipv6_nxt = csum_offload_enable ? is_ipv6 : ipv6_r;
  assign ipv4_nxt = csum_offload_enable ? is_ipv4 : ipv4_r;
  assign ip_any   = ipv6_nxt | ipv4_nxt;
  // errors only meaningful when an ip bit is reported
  assign hdr_err  = ip_any & (hdr_csum_bad | ver_mismatch);
  assign pay_err  = ip_any & (pay_csum_bad | seg_len_bad);
  // codes 11..14 are never produced; reserved types report 15
  assign msg_code = (ptp_msg > MSG_SIGNALING && ptp_msg != MSG_RESERVED) ?
                    MSG_RESERVED : ptp_msg;
  // header error or fragment forces unknown payload
  assign pay_code = (!ip_any || hdr_err || is_fragment || l4_kind > PAY_ICMP) ?
                    PAY_UNKNOWN : l4_kind;

  // assemble word, reserved bits zero
  always_comb begin
    w4_nxt = 32'h0000_0000;
    w4_nxt[W4_TS_DROP_BIT] = ts_captured & fifo_overflow;
    w4_nxt[W4_PTP_VER_BIT] = ptp_v2;
    w4_nxt[W4_PTP_ETH_BIT] = ptp_over_eth & (msg_code != MSG_NONE);
    w4_nxt[W4_MSG_LSB +: 4] = msg_code;
    w4_nxt[W4_IPV6_BIT] = ipv6_nxt;
    w4_nxt[W4_IPV4_BIT] = ipv4_nxt;
    w4_nxt[W4_BYPASS_BIT] = csum_engine_bypass;
    w4_nxt[W4_PAY_ERR_BIT] = pay_err;
    w4_nxt[W4_HDR_ERR_BIT] = hdr_err;
    w4_nxt[W4_PAY_TYPE_LSB +: 3] = pay_code;
  end

  // capture summary at frame end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ipv6_r         <= 1'b0;
      ipv4_r         <= 1'b0;
      wb.frame_valid <= 1'b0;
      wb.word4       <= 32'h0000_0000;
      wb.stamp       <= 64'h0;
      wb.is_last     <= 1'b0;
    end else begin
      wb.frame_valid <= frame_end & ~wb.busy;
      if (frame_end && !wb.busy) begin
        ipv6_r     <= ipv6_nxt;
        ipv4_r     <= ipv4_nxt;
        wb.word4   <= w4_nxt;
        wb.stamp   <= stamp;
        wb.is_last <= is_last;
      end
    end
  end
endmodule
`default_nettype wire

// ==== design/rxw_seq.sv ====
/*
  writes word 4, 6 and 7 of the last descriptor into host memory, one
  word a cycle. assumes the memory port accepts a write every cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module rxw_seq
  import rxw_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // from composer
  rxw_wb_if.dst            wb,
  // descriptor write port
  output logic             mem_we,
  output logic [2:0]       mem_word,
  output logic [31:0]      mem_data,
  output logic             done
);
  rxw_state_type state_r;  // current writeback step
  rxw_state_type state_nxt;
  logic [63:0]   stamp_r;   // held timestamp

  assign wb.busy = (state_r != ST_IDLE);

  // next-state choice
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (wb.frame_valid && wb.is_last) state_nxt = ST_W4;
      ST_W4:   state_nxt = ST_W6;
      ST_W6:   state_nxt = ST_W7;
      ST_W7:   state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // write port outputs registered from the state about to be entered, done from the current state
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r  <= ST_IDLE;
      stamp_r  <= 64'h0;
      mem_we   <= 1'b0;
      mem_word <= 3'h0;
      mem_data <= 32'h0000_0000;
      done     <= 1'b0;
    end else begin
      state_r <= state_nxt;
      done    <= (state_r == ST_W7);
      mem_we  <= (state_nxt != ST_IDLE);
      // word four leaves the cycle it arrives, so only the stamp is held
      if (state_r == ST_IDLE && wb.frame_valid) begin
        stamp_r <= wb.stamp;
      end
      case (state_nxt)
        ST_W4: begin
          mem_word <= 3'h4;
          mem_data <= wb.word4;
        end
        ST_W6: begin
          mem_word <= 3'h6;
          mem_data <= stamp_r[31:0];
        end
        ST_W7: begin
          mem_word <= 3'h7;
          mem_data <= stamp_r[63:32];
        end
        default: begin
          mem_word <= 3'h0;
          mem_data <= 32'h0000_0000;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== design/rxw_top.sv ====
/*
  receive extended status and timestamp writeback with a small register
  port for control, events and interrupt. assumes all inputs are on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module rxw_top
  import rxw_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // receive path summary
  input  wire logic        frame_end,
  input  wire logic [31:0] rx_desc_word0_status,
  input  wire logic [63:0] rx_frame_timestamp,
  input  wire logic        ts_captured,
  input  wire logic        fifo_overflow,
  input  wire logic        ptp_v2,
  input  wire logic        ptp_over_eth,
  input  wire logic [3:0]  ptp_msg,
  input  wire logic        is_ipv6,
  input  wire logic        is_ipv4,
  input  wire logic        csum_engine_bypass,
  input  wire logic        pay_csum_bad,
  input  wire logic        seg_len_bad,
  input  wire logic        hdr_csum_bad,
  input  wire logic        ver_mismatch,
  input  wire logic        is_fragment,
  input  wire logic [2:0]  l4_kind,
  // descriptor write port
  output logic             mem_we,
  output logic [2:0]       mem_word,
  output logic [31:0]      mem_data,
  // interrupt
  output logic             irq
);
  rxw_wb_if wb ();
  logic [31:0] ctrl_r;     // bit 0: checksum_offload_enable
  logic [EV_COUNT-1:0] stat_r;
  logic [EV_COUNT-1:0] irq_en_r;
  logic [EV_COUNT-1:0] ev;
  logic [EV_COUNT-1:0] clr;
  logic [15:0] frames_r;   // frames written back, wraps
  logic        wb_done;
  logic        wr_ctrl;
  logic        wr_clear;
  logic        wr_en;
  logic [31:0] rd_mux;

  rxw_compose u_compose (
    .core_clk            (core_clk),
    .rst_b               (rst_b),
    .frame_end           (frame_end),
    .is_last             (rx_desc_word0_status[W0_LAST_BIT]),
    .stamp               (rx_frame_timestamp),
    .ts_captured         (ts_captured),
    .fifo_overflow       (fifo_overflow),
    .ptp_v2              (ptp_v2),
    .ptp_over_eth        (ptp_over_eth),
    .ptp_msg             (ptp_msg),
    .is_ipv6             (is_ipv6),
    .is_ipv4             (is_ipv4),
    .csum_engine_bypass  (csum_engine_bypass),
    .pay_csum_bad        (pay_csum_bad),
    .seg_len_bad         (seg_len_bad),
    .hdr_csum_bad        (hdr_csum_bad),
    .ver_mismatch        (ver_mismatch),
    .is_fragment         (is_fragment),
    .l4_kind             (l4_kind),
    .csum_offload_enable (ctrl_r[0]),
    .wb                  (wb.src)
  );

  rxw_seq u_seq (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .wb       (wb.dst),
    .mem_we   (mem_we),
    .mem_word (mem_word),
    .mem_data (mem_data),
    .done     (wb_done)
  );

  // register decode
  assign wr_ctrl  = reg_wr && (reg_addr == REG_CTRL);
  assign wr_clear = reg_wr && (reg_addr == REG_CLEAR);
  assign wr_en    = reg_wr && (reg_addr == REG_IRQ_EN);
  assign clr      = wr_clear ? reg_wdata[EV_COUNT-1:0] : '0;
  // done from the sequencer; drop and checksum events from the composed word as it leaves for writeback
  assign ev[EV_DONE]     = wb_done;
  assign ev[EV_TS_DROP]  = wb.frame_valid & wb.word4[W4_TS_DROP_BIT];
  assign ev[EV_CSUM_ERR] = wb.frame_valid &
                           (wb.word4[W4_PAY_ERR_BIT] | wb.word4[W4_HDR_ERR_BIT]);
  // unmapped addresses read zero
  assign rd_mux = (reg_addr == REG_CTRL)    ? ctrl_r :
                  (reg_addr == REG_STATUS)  ? {29'h0, stat_r} :
                  (reg_addr == REG_IRQ_EN)  ? {29'h0, irq_en_r} :
                  (reg_addr == REG_LAST_W4) ? wb.word4 :
                  (reg_addr == REG_FRAMES)  ? {16'h0, frames_r} : 32'h0000_0000;

  // sticky status: set wins over clear
  genvar gi;
  generate
    for (gi = 0; gi < EV_COUNT; gi++) begin : g_stat
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) stat_r[gi] <= 1'b0;
        else stat_r[gi] <= ev[gi] | (stat_r[gi] & ~clr[gi]);
      end
    end
  endgenerate

  // control, enable, counter, read data, interrupt
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r    <= RST_CTRL;
      irq_en_r  <= RST_IRQ_EN;
      frames_r  <= 16'h0;
      reg_rdata <= 32'h0000_0000;
      irq       <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_r <= {31'h0, reg_wdata[0]};
      if (wr_en) irq_en_r <= reg_wdata[EV_COUNT-1:0];
      if (wb_done) frames_r <= frames_r + 16'h1;
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
      irq       <= |((ev | (stat_r & ~clr)) & irq_en_r);
    end
  end
endmodule
`default_nettype wire

// ==== bench/rxw_asserts.sv ====
/*
  checker for the writeback block: beat order, stamps, word four fields.
  assumes it is bound to rxw_top, one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module rxw_asserts (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst_b,
  // frame summary
  input wire logic        frame_end,
  input wire logic [31:0] rx_desc_word0_status,
  input wire logic [63:0] rx_frame_timestamp,
  input wire logic        ts_captured,
  input wire logic        fifo_overflow,
  input wire logic        ptp_v2,
  input wire logic [3:0]  ptp_msg,
  input wire logic        csum_engine_bypass,
  // descriptor port and interrupt
  input wire logic        mem_we,
  input wire logic [2:0]  mem_word,
  input wire logic [31:0] mem_data,
  input wire logic        irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // word four beat, two cycles after the frame summary
  wire logic w4 = mem_we && mem_word == 3'h4;
  chk_last_only: assert property ($rose(mem_we) |->
    $past(frame_end, 2) && $past(rx_desc_word0_status[8], 2)) else $error("write without last frame");
  chk_word_order: assert property ($rose(mem_we) |-> mem_word == 3'h4 ##1
    mem_we && mem_word == 3'h6 ##1 mem_we && mem_word == 3'h7 ##1 !mem_we) else $error("bad beats");
  chk_stamp_low: assert property (mem_we && mem_word == 3'h6 |->
    mem_data == $past(rx_frame_timestamp[31:0], 3)) else $error("word6 wrong");
  chk_stamp_high: assert property (mem_we && mem_word == 3'h7 |->
    mem_data == $past(rx_frame_timestamp[63:32], 4)) else $error("word7 wrong");
  chk_reserved_zero: assert property (w4 |-> mem_data[31:15] == 17'h0)
    else $error("reserved bits set");
  chk_ts_drop: assert property (w4 |->
    mem_data[14] == ($past(ts_captured, 2) && $past(fifo_overflow, 2))) else $error("ts drop");
  chk_ptp_ver: assert property (w4 |-> mem_data[13] == $past(ptp_v2, 2))
    else $error("version bit wrong");
  chk_msg_code: assert property (w4 && $past(ptp_msg, 2) < 4'hb |->
    mem_data[11:8] == $past(ptp_msg, 2)) else $error("message code wrong");
  chk_bypass_bit: assert property (w4 |-> mem_data[5] == $past(csum_engine_bypass, 2))
    else $error("bypass bit wrong");
  // main scenarios reached
  cover property (mem_we && mem_word == 3'h7);
  cover property (irq);
  cover property (frame_end && !rx_desc_word0_status[8]);
endmodule
bind rxw_top rxw_asserts u_chk (.core_clk(core_clk), .rst_b(rst_b), .frame_end(frame_end),
  .rx_desc_word0_status(rx_desc_word0_status), .rx_frame_timestamp(rx_frame_timestamp),
  .ts_captured(ts_captured), .fifo_overflow(fifo_overflow), .ptp_v2(ptp_v2), .ptp_msg(ptp_msg),
  .csum_engine_bypass(csum_engine_bypass), .mem_we(mem_we), .mem_word(mem_word),
  .mem_data(mem_data), .irq(irq));
`default_nettype wire

// ==== bench/rxw_host_mem.sv ====
/*
  host memory model: one descriptor of eight words, write count.
  assumes a write every cycle is accepted, as the host port never stalls.
*/
`timescale 1ns/1ps
`default_nettype none
module rxw_host_mem (
  // descriptor write port
  input wire logic        core_clk,
  input wire logic        mem_we,
  input wire logic [2:0]  mem_word,
  input wire logic [31:0] mem_data
);
  logic [31:0] desc [0:7];  // descriptor words as seen by software
  int          n_wr = 0;    // writes accepted so far
  // store each beat; no wait states, like host memory behind the dma
  always @(posedge core_clk) begin
    if (mem_we) begin
      desc[mem_word] <= mem_data;
      n_wr <= n_wr + 1;
    end
  end
endmodule
`default_nettype wire

// ==== bench/rxw_top_tb_top.sv ====
/*
  bench for rxw_top: registers, message codes, ip fields, stamps, irq.
  assumes the host model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module rxw_top_tb_top;
  import rxw_pkg::*;
  logic core_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, frame_end = 1'b0;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, mem_data, rx_desc_word0_status = 32'h0;
  logic [63:0] rx_frame_timestamp = 64'h0;
  logic ts_captured = 1'b0, fifo_overflow = 1'b0, ptp_v2 = 1'b0, ptp_over_eth = 1'b0;
  logic is_ipv6 = 1'b0, is_ipv4 = 1'b0, csum_engine_bypass = 1'b0, pay_csum_bad = 1'b0;
  logic seg_len_bad = 1'b0, hdr_csum_bad = 1'b0, ver_mismatch = 1'b0, is_fragment = 1'b0;
  logic [3:0] ptp_msg = 4'h0;
  logic [2:0] l4_kind = 3'h0, mem_word;
  logic mem_we, irq;
  logic offload_on = 1'b1, p6 = 1'b0, p4 = 1'b0;  // offload state, ip bits of last frame
  int err_count = 0, checks_done = 0;
  rxw_top u_dut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_end(frame_end),
    .rx_desc_word0_status(rx_desc_word0_status), .rx_frame_timestamp(rx_frame_timestamp),
    .ts_captured(ts_captured), .fifo_overflow(fifo_overflow), .ptp_v2(ptp_v2),
    .ptp_over_eth(ptp_over_eth), .ptp_msg(ptp_msg), .is_ipv6(is_ipv6), .is_ipv4(is_ipv4),
    .csum_engine_bypass(csum_engine_bypass), .pay_csum_bad(pay_csum_bad),
    .seg_len_bad(seg_len_bad), .hdr_csum_bad(hdr_csum_bad), .ver_mismatch(ver_mismatch),
    .is_fragment(is_fragment),
    .l4_kind(l4_kind), .mem_we(mem_we), .mem_word(mem_word), .mem_data(mem_data), .irq(irq));
  rxw_host_mem u_mem (.core_clk(core_clk), .mem_we(mem_we), .mem_word(mem_word),
    .mem_data(mem_data));
  // 25 mhz clock
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  // word four as the inputs now stand; ip bits hold while offload is off,
  // errors and payload type read zero without an ip bit
  function automatic logic [31:0] exp_w4();
    logic [31:0] w;
    logic [1:0]  ip;
    logic        herr;
    w = 32'h0;
    ip = offload_on ? {is_ipv6, is_ipv4} : {p6, p4};
    herr = (|ip) & (hdr_csum_bad | ver_mismatch);
    w[14] = ts_captured & fifo_overflow;
    w[13] = ptp_v2;
    w[12] = ptp_over_eth && ptp_msg != 4'h0;
    w[11:8] = (ptp_msg > 4'ha && ptp_msg < 4'hf) ? 4'hf : ptp_msg;
    w[7:6] = ip;
    w[5] = csum_engine_bypass;
    w[4] = (|ip) & (pay_csum_bad | seg_len_bad);
    w[3] = herr;
    w[2:0] = (ip == 2'b00 || herr || is_fragment || l4_kind[2]) ? 3'h0 : l4_kind;
    return w;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // one frame summary, then the whole writeback window
  task automatic frame(input logic last);
    int n;
    logic [31:0] e;
    n = u_mem.n_wr;
    e = exp_w4();
    rx_desc_word0_status <= {23'h0, last, 8'h0};
    frame_end <= 1'b1;
    @(posedge core_clk);
    frame_end <= 1'b0;
    repeat (5) @(posedge core_clk);
    #1;
    `CHK("writes", last ? n + 3 : n, u_mem.n_wr)
    if (last) begin
      `CHK("word4", e, u_mem.desc[4])
      `CHK("word6", rx_frame_timestamp[31:0], u_mem.desc[6])
      `CHK("word7", rx_frame_timestamp[63:32], u_mem.desc[7])
    end
    // the composer takes ip bits on every accepted frame, last or not
    if (offload_on) {p6, p4} = {is_ipv6, is_ipv4};
  endtask
  task automatic t_regs();
    logic [31:0] d;
    rd(REG_CTRL, d);
    `CHK("ctrl", RST_CTRL, d)
    rd(REG_IRQ_EN, d);
    `CHK("irq_en", 32'h0, d)
    rd(8'h40, d);
    `CHK("unmapped", 32'h0, d)
    $display("regs done");
  endtask
  // every message code, with version and carrier varied
  task automatic t_msg();
    for (int m = 0; m < 16; m++) begin
      ptp_msg <= 4'(m);
      ptp_v2 <= m[0];
      ptp_over_eth <= m[1];
      @(posedge core_clk);
      frame(1'b1);
      `CHK("msg", (m > 10 && m < 15) ? 4'hf : 4'(m), u_mem.desc[4][11:8])
      `CHK("eth", m[1] && m != 0, u_mem.desc[4][12])
    end
    $display("msg done");
  endtask
  // every payload kind, errors, a fragment, offload off, then no ip at all
  task automatic t_ip();
    for (int k = 0; k < 8; k++) begin
      {is_ipv6, is_ipv4} <= {k[0], !k[0]};
      l4_kind <= (k == 4) ? 3'h4 : 3'(k % 4);
      pay_csum_bad <= k == 1;
      seg_len_bad <= k == 3;
      hdr_csum_bad <= k == 6;
      ver_mismatch <= k == 5;
      is_fragment <= k == 7;
      @(posedge core_clk);
      frame(1'b1);
      `CHK("ptype", (k < 4) ? 3'(k) : 3'h0, u_mem.desc[4][2:0])
      `CHK("payerr", k == 1 || k == 3, u_mem.desc[4][4])
      `CHK("hdrerr", k == 5 || k == 6, u_mem.desc[4][3])
    end
    wr(REG_CTRL, 32'h0);
    offload_on = 1'b0;
    {is_ipv6, is_ipv4, seg_len_bad, ver_mismatch} <= 4'h4;
    @(posedge core_clk);
    frame(1'b1);
    `CHK("iphold", {p6, p4}, u_mem.desc[4][7:6])
    wr(REG_CTRL, 32'h1);
    offload_on = 1'b1;
    {is_ipv6, is_ipv4, pay_csum_bad, hdr_csum_bad} <= 4'h3;
    {is_fragment, l4_kind} <= {1'b0, PAY_UDP};
    @(posedge core_clk);
    frame(1'b1);
    `CHK("noip", 5'h0, u_mem.desc[4][4:0])
    $display("ip done");
  endtask
  // dropped stamp, bypass, status and interrupt, then a non-last frame
  task automatic t_ts();
    logic [31:0] d, e;
    wr(REG_CLEAR, 32'h7);
    wr(REG_IRQ_EN, 32'h1);
    rd(REG_STATUS, d);
    `CHK("stat_clr", 32'h0, d)
    `CHK("irq_idle", 1'b0, irq)
    rx_frame_timestamp <= 64'h0123_4567_89ab_cdef;
    {ts_captured, fifo_overflow, csum_engine_bypass} <= 3'h7;
    @(posedge core_clk);
    e = exp_w4();
    frame(1'b1);
    `CHK("tsdrop", 1'b1, u_mem.desc[4][14])
    rd(REG_STATUS, d);
    `CHK("done", 1'b1, d[EV_DONE])
    `CHK("ts_event", 1'b1, d[EV_TS_DROP])
    `CHK("irq", 1'b1, irq)
    rd(REG_LAST_W4, d);
    `CHK("last_w4", e, d)
    // sixteen message frames, ten ip frames and this one
    rd(REG_FRAMES, d);
    `CHK("frames", 32'h0000_001b, d)
    wr(REG_CLEAR, 32'h7);
    repeat (2) @(posedge core_clk);
    #1;
    `CHK("irq_clr", 1'b0, irq)
    rx_frame_timestamp <= 64'hfedc_ba98_7654_3210;
    frame(1'b0);
    `CHK("word6_kept", 32'h89ab_cdef, u_mem.desc[6])
    $display("stamp done");
  endtask
  // reset in mid-run with the interrupt up: irq, write enable, control, irq enable and frame count back to reset values
  task automatic t_reset();
    logic [31:0] d;
    wr(REG_IRQ_EN, 32'h7);
    @(posedge core_clk);
    #1;
    `CHK("irq_up", 1'b1, irq)
    rst_b <= 1'b0;
    @(posedge core_clk);
    #1;
    `CHK("irq_rst", 1'b0, irq)
    `CHK("we_rst", 1'b0, mem_we)
    rst_b <= 1'b1;
    {p6, p4} = 2'b00;
    rd(REG_CTRL, d);
    `CHK("ctrl_rst", RST_CTRL, d)
    rd(REG_IRQ_EN, d);
    `CHK("irq_en_rst", 32'h0, d)
    rd(REG_FRAMES, d);
    `CHK("frames_rst", 32'h0, d)
    $display("reset done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // hang guard, well past the few hundred cycles the tests need
  initial begin
    #100000;
    err_count++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    t_regs();
    t_msg();
    t_ip();
    t_ts();
    t_reset();
    complete_run();
  end
endmodule
`default_nettype wire
